// *** hdl/link_crc_pkg.sv ***
package link_crc_pkg;

  // CRC arithmetic.
  localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
  localparam logic [31:0] CRC_SEED = 32'hFFFFFFFF;
  localparam int CRC_STEP_BITS = 9;

  // Window geometry at 8-bit width, in bit-times; narrower links scale it up.
  localparam logic [11:0] WIN_BASE = 12'h200;
  localparam logic [11:0] INS_BASE = 12'h040;
  localparam logic [11:0] SLOT_BASE = 12'h004;
  localparam logic [4:0] HOLD_BT = 5'h10;
  localparam logic [3:0] ATOMIC_COUNT = 4'h1;

  // Avalon-MM register map, byte addresses.
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_FLAGS = 4'h4;
  localparam logic [3:0] REG_ROUTE = 4'h8;
  localparam logic [3:0] REG_CRC = 4'hC;

  typedef enum logic [2:0] {W2 = 3'h0, W4 = 3'h1, W8 = 3'h2, W16 = 3'h3, W32 = 3'h4} width_t;
  typedef enum logic [1:0] {LS_IDLE = 2'h0, LS_FIRST = 2'h1, LS_RUN = 2'h3} link_st_t;

  typedef struct packed {
    logic en;
    logic ctl_to_long;
    logic drop_uninit;
    logic init_done;
    logic eoc;
    logic diag;
    width_t width;
  } ctrl_t;
  localparam int CTRL_W = $bits(ctrl_t);

  typedef struct packed {
    logic resp;
    logic inb_eoc;
    logic eoc;
    logic ovf;
    logic prot;
    logic flood;
    logic [3:0] crc;
  } flags_t;
  localparam int FLAGS_W = $bits(flags_t);

  // Error classes, MSB first: crc, resp, eoc, ovf, prot.
  typedef struct packed {
    logic [4:0] nf;
    logic [4:0] fat;
    logic [4:0] fl;
  } route_t;
  localparam int ROUTE_W = $bits(route_t);
  localparam logic [4:0] FLOOD_OK = 5'h13;

  typedef struct packed {
    logic cmd_valid;
    logic has_data;
    logic bad_cmd;
    logic no_buffer;
    logic data_pending;
  } pkt_ev_t;

  typedef struct packed {
    logic valid;
    logic posted;
    logic is_read;
  } dir_pkt_t;

  typedef struct packed {
    logic valid;
    logic tag_outstanding;
    logic is_rdresp;
    logic req_wr_or_flush;
    logic req_rd;
    logic req_atomic;
    logic [3:0] count;
    logic [3:0] req_count;
  } resp_in_t;

  typedef struct packed {
    logic valid;
    logic error;
    logic nxa;
    logic is_rdresp;
    logic [31:0] data;
  } rsp_out_t;

endpackage

// *** hdl/link_crc_err.sv ***
`timescale 1ns/1ps
// Contract
// - Each lane's check value is the remainder by polynomial 0x04C11DB7.
// - Accumulator is seeded with all ones at every window start.
// - No thirty-two zero bits are appended; the accumulator is the result.
// - Sender inverts the check value; receiver compares against inverted form.
// - Nine bits per bit-time, LSB first: save bit 31, shift in, conditional XOR.
// - Receiver sets the mismatching lane's check-error flag; routable to three paths.
// - Check-error flag waits 16 bit-times so a sync flood can win.
// - Narrow links produce the 8-bit check value; surplus CTL bits ignored.
// - Narrow input is consecutive CAD beats then the first CTL, LSB first.
// - Window, insertion, duration: 512/64/4, 1024/128/8, 2048/256/16 bit-times.
// - CTL change off a 4-byte boundary is a protocol error outside diagnostics.
// - CTL low without pending data, during check value, or past timeout: error; with diag set the code flags only the timeout.
// - Data command while data pending, or bad command encoding: protocol error.
// - Any protocol error sets the protocol flag; routable to three paths.
// - Packet with no free receive buffer sets the overflow flag.
// - Directed packet to end-of-chain transmitter is dropped; uninitialized counts.
// - Dropped nonposted request answered with Error, NXA, all-ones data; no log.
// - Dropped posted request or response sets the end-of-chain flag.
// - Unaccepted posted packet from the other host sets inbound end-of-chain flag.
// - Chain down flushes outstanding nonposted state with non-NXA error answers.
// - Response errors: unknown tag, wrong response kind, or wrong count.
// - Every response error sets the response-error flag; fatal or nonfatal only.
// - No check value in the first window; check bits excluded from computation.
// - Windows counted in bit-times from the first valid packet after sync.
// - While the check value is sent, CTL is driven high.
// - Wide links run one check per byte lane; lanes without CTL use zero.
module link_crc_err import link_crc_pkg::*; #(
  // Chosen CTL timeout counts at 125 MHz (1 ms and 1 s); shorten for simulation.
  parameter logic [26:0] CTL_TO_SHORT_CYC = 27'h001E848,
  parameter logic [26:0] CTL_TO_LONG_CYC = 27'h7735940
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Receive link pins
  input wire logic link_clk,
  input wire logic [31:0] link_cad_in,
  input wire logic link_ctl_in,
  input wire logic link_reset_n,
  // Transmit stream from packet logic and to the link
  input wire logic [31:0] tx_cad,
  input wire logic tx_ctl,
  output logic tx_take_q,
  output logic [31:0] tx_cad_q,
  output logic tx_ctl_q,
  // Packet-level events
  input wire pkt_ev_t pkt_ev,
  input wire dir_pkt_t dir_pkt,
  input wire logic inb_unaccepted,
  input wire resp_in_t resp_in,
  // Answers and error routing
  output rsp_out_t nxa_rsp_q,
  output logic np_flush_q,
  output logic flood_req_q,
  output logic fatal_q,
  output logic nonfatal_q
);

  typedef struct packed {
    logic [2:0] clk_s;
    logic [31:0] cad_s1;
    logic [31:0] cad_s2;
    logic [1:0] ctl_s;
    logic [2:0] rstn_s;
    ctrl_t ctrl;
    flags_t flags;
    route_t route;
    logic wait_q;
    logic [31:0] rdata;
    link_st_t [1:0] st;
    logic [1:0][11:0] pos;
    logic [1:0][1:0] gc;
    logic [1:0][7:0] gbyte;
    logic [1:0] gctl;
    logic [1:0][3:0][31:0] acc;
    logic [1:0][3:0][31:0] prev;
    logic [3:0][31:0] rxcrc;
    logic [3:0] mism;
    logic holding;
    logic [4:0] hold;
    logic [4:0] ones;
    logic flood;
    logic [1:0] bphase;
    logic ctl_last;
    logic [26:0] to_cnt;
    logic [31:0] cad_o;
    logic ctl_o;
    logic take;
    rsp_out_t rsp;
    logic flush;
    logic fl_o;
    logic fat_o;
    logic nf_o;
  } state_t;

  state_t s_q, s_d;
  logic tx_ins;

  function automatic logic [31:0] crc9(input logic [31:0] c, input logic [8:0] d);
    logic t;
    logic [31:0] r;
    r = c;
    for (int i = 0; i < CRC_STEP_BITS; i++) begin
      t = r[31];
      r = {r[30:0], d[i]};
      if (t) begin
        r = r ^ CRC_POLY;
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] cad_mask(input width_t w);
    case (w)
      W2: return 32'h00000003;
      W4: return 32'h0000000F;
      W8: return 32'h000000FF;
      W16: return 32'h0000FFFF;
      default: return 32'hFFFFFFFF;
    endcase
  endfunction

  function automatic logic [3:0] lanes_of(input width_t w);
    case (w)
      W16: return 4'h3;
      W32: return 4'hF;
      default: return 4'h1;
    endcase
  endfunction

  always_comb begin
    logic bt;
    logic [31:0] cad;
    logic ctl;
    logic act;
    logic slot;
    logic [1:0] sh;
    logic [11:0] win;
    logic [11:0] ins;
    logic [11:0] nsl;
    logic [11:0] si;
    logic [4:0] shamt;
    logic [31:0] m;
    logic [3:0] ln;
    logic [7:0] byte0;
    logic [8:0] d9;
    logic [31:0] cap;
    logic [3:0][31:0] acc_n;
    logic bus_wr;
    logic [4:0] cls;
    logic [26:0] to_lim;
    logic eoc_act;
    logic resp_bad;
    flags_t set;
    bt = 1'b0;
    cad = '0;
    ctl = 1'b0;
    act = 1'b0;
    slot = 1'b0;
    si = '0;
    shamt = '0;
    byte0 = '0;
    d9 = '0;
    cap = '0;
    acc_n = '0;
    set = '0;
    sh = '0;
    win = '0;
    ins = '0;
    nsl = '0;
    m = '0;
    ln = '0;
    bus_wr = 1'b0;
    cls = '0;
    to_lim = '0;
    eoc_act = 1'b0;
    resp_bad = 1'b0;
    tx_ins = 1'b0;
    s_d = s_q;
    s_d.take = 1'b0;
    s_d.rsp = '0;
    s_d.flush = 1'b0;

    // Link pins cross into mclk through two flops before anything looks at them.
    s_d.clk_s = {s_q.clk_s[1:0], link_clk};
    s_d.cad_s1 = link_cad_in;
    s_d.cad_s2 = s_q.cad_s1;
    s_d.ctl_s = {s_q.ctl_s[0], link_ctl_in};
    s_d.rstn_s = {s_q.rstn_s[1:0], link_reset_n};
    bt = s_q.clk_s[1] & ~s_q.clk_s[2];

    sh = (s_q.ctrl.width == W2) ? 2'h2 : (s_q.ctrl.width == W4) ? 2'h1 : 2'h0;
    win = WIN_BASE << sh;
    ins = INS_BASE << sh;
    nsl = SLOT_BASE << sh;
    m = cad_mask(s_q.ctrl.width);
    ln = lanes_of(s_q.ctrl.width);

    for (int d = 0; d < 2; d++) begin
      cad = (d == 1) ? tx_cad : s_q.cad_s2;
      ctl = (d == 1) ? tx_ctl : s_q.ctl_s[1];
      act = 1'b0;
      if (bt && s_q.ctrl.en && s_q.rstn_s[2]) begin
        if (s_q.st[d] == LS_IDLE) begin
          // Windows start at the first control beat that is not a sync pattern.
          if (ctl && ((cad & m) != m)) begin
            s_d.st[d] = LS_FIRST;
            s_d.pos[d] = '0;
            s_d.gc[d] = '0;
            s_q_acc_seed: for (int l = 0; l < 4; l++) begin
              s_d.acc[d][l] = CRC_SEED;
            end
            act = 1'b1;
          end
        end else begin
          act = 1'b1;
        end
      end
      acc_n = s_d.acc[d];
      if (act) begin
        slot = (s_q.st[d] == LS_RUN) && (s_q.pos[d] >= ins)
            && (s_q.pos[d] < ins + nsl);
        si = s_q.pos[d] - ins;
        shamt = 5'({1'b0, si[3:0]} << (2'h3 - sh));
        if (slot) begin
          // Check bits never enter the accumulator.
          for (int l = 0; l < 4; l++) begin
            if (d == 1) begin
              s_d.cad_o[8*l +: 8] = 8'((~s_q.prev[1][l]) >> shamt) & m[7:0];
            end else if (ln[l]) begin
              cap = (si == '0) ? '0 : s_q.rxcrc[l];
              cap = cap | (32'(s_q.cad_s2[8*l +: 8] & m[7:0]) << shamt);
              s_d.rxcrc[l] = cap;
              if (si == nsl - 12'h001) begin
                s_d.mism[l] = (cap != ~s_q.prev[0][l]) && !s_q.flood;
              end
            end
          end
          if (d == 1) begin
            s_d.ctl_o = 1'b1;
            tx_ins = 1'b1;
          end else if (si == nsl - 12'h001 && !s_q.flood) begin
            s_d.holding = 1'b1;
            s_d.hold = '0;
          end
        end else begin
          byte0 = (s_q.gc[d] == '0) ? 8'h00 : s_q.gbyte[d];
          byte0 = byte0 | 8'((cad[7:0] & m[7:0]) << shamt_g(s_q.gc[d], sh));
          s_d.gbyte[d] = byte0;
          if (s_q.gc[d] == '0) begin
            s_d.gctl[d] = ctl;
          end
          if (s_q.gc[d] == 2'((3'h1 << sh) - 3'h1)) begin
            s_d.gc[d] = '0;
            for (int l = 0; l < 4; l++) begin
              // Lanes above the first carry no CTL, so zero stands in.
              d9 = (l == 0) ? {(s_q.gc[d] == '0) ? ctl : s_q.gctl[d], byte0}
                            : {1'b0, cad[8*l +: 8]};
              acc_n[l] = crc9(s_d.acc[d][l], d9);
            end
          end else begin
            s_d.gc[d] = s_q.gc[d] + 2'h1;
          end
          s_d.acc[d] = acc_n;
          if (d == 1) begin
            s_d.cad_o = tx_cad;
            s_d.ctl_o = tx_ctl;
            s_d.take = 1'b1;
          end
        end
        if (s_q.pos[d] == win - 12'h001 + ((s_q.st[d] == LS_RUN) ? nsl : 12'h000)) begin
          // The raw accumulator is the result; nothing is flushed through it.
          s_d.prev[d] = acc_n;
          for (int l = 0; l < 4; l++) begin
            s_d.acc[d][l] = CRC_SEED;
          end
          s_d.st[d] = LS_RUN;
          s_d.pos[d] = '0;
        end else begin
          s_d.pos[d] = s_q.pos[d] + 12'h001;
        end
        if (d == 0 && !s_q.ctrl.diag) begin
          if (ctl != s_q.ctl_last && (s_q.bphase != '0 || s_q.gc[0] != '0)) begin
            set.prot = 1'b1;
          end
          if (!ctl && (slot || !pkt_ev.data_pending)) begin
            set.prot = 1'b1;
          end
        end
        if (d == 0 && !slot) begin
          s_d.ctl_last = ctl;
          if (s_q.gc[0] == 2'((3'h1 << sh) - 3'h1)) begin
            s_d.bphase = s_q.bphase + ((s_q.ctrl.width == W16) ? 2'h2
                       : (s_q.ctrl.width == W32) ? 2'h0 : 2'h1);
          end
        end
      end else if (d == 1 && bt) begin
        s_d.cad_o = tx_cad;
        s_d.ctl_o = tx_ctl;
        s_d.take = 1'b1;
      end
    end

    // Sync flood: CAD and CTL all ones for the hold-off span.
    if (bt && s_q.st[0] != LS_IDLE) begin
      if (s_q.ctl_s[1] && ((s_q.cad_s2 & m) == m)) begin
        s_d.ones = (s_q.ones == HOLD_BT) ? s_q.ones : s_q.ones + 5'h01;
        if (s_q.ones == HOLD_BT - 5'h01) begin
          s_d.flood = 1'b1;
          set.flood = 1'b1;
        end
      end else begin
        s_d.ones = '0;
      end
      if (s_q.holding) begin
        s_d.hold = s_q.hold + 5'h01;
        // The flag waits so a flood that began on the check bits is not blamed on them.
        if (s_q.flood) begin
          s_d.holding = 1'b0;
        end else if (s_q.hold == HOLD_BT - 5'h01) begin
          set.crc = s_q.mism & ln;
          s_d.holding = 1'b0;
        end
      end
    end

    // CTL timeout runs on mclk so it keeps counting while the link clock idles.
    to_lim = s_q.ctrl.ctl_to_long ? CTL_TO_LONG_CYC : CTL_TO_SHORT_CYC;
    if (s_q.st[0] != LS_IDLE && !s_q.ctl_s[1]) begin
      s_d.to_cnt = (s_q.to_cnt == to_lim) ? s_q.to_cnt : s_q.to_cnt + 27'h0000001;
      if (s_q.to_cnt == to_lim - 27'h0000001) begin
        set.prot = 1'b1;
      end
    end else begin
      s_d.to_cnt = '0;
    end

    if (pkt_ev.bad_cmd || (pkt_ev.cmd_valid && pkt_ev.has_data && pkt_ev.data_pending)) begin
      set.prot = 1'b1;
    end
    if (pkt_ev.no_buffer) begin
      set.ovf = 1'b1;
    end

    eoc_act = s_q.ctrl.eoc || (!s_q.ctrl.init_done && s_q.ctrl.drop_uninit);
    if (dir_pkt.valid && eoc_act) begin
      if (dir_pkt.posted) begin
        set.eoc = 1'b1;
      end else begin
        s_d.rsp = '{valid: 1'b1, error: 1'b1, nxa: 1'b1, is_rdresp: dir_pkt.is_read,
                    data: 32'hFFFFFFFF};
      end
    end
    if (inb_unaccepted) begin
      set.inb_eoc = 1'b1;
    end

    resp_bad = !resp_in.tag_outstanding
            || (resp_in.is_rdresp && resp_in.req_wr_or_flush)
            || (!resp_in.is_rdresp && (resp_in.req_rd || resp_in.req_atomic))
            || (resp_in.is_rdresp && resp_in.req_rd && resp_in.count != resp_in.req_count)
            || (resp_in.is_rdresp && resp_in.req_atomic && resp_in.count != ATOMIC_COUNT);
    if (resp_in.valid && resp_bad) begin
      set.resp = 1'b1;
    end

    // Chain down: flood onset or the assertion edge of link reset.
    if ((s_d.flood && !s_q.flood) || (s_q.rstn_s[2] && !s_q.rstn_s[1])) begin
      s_d.flush = 1'b1;
    end
    if (!s_q.rstn_s[2]) begin
      s_d.st = {LS_IDLE, LS_IDLE};
      s_d.flood = 1'b0;
      s_d.holding = 1'b0;
      s_d.ones = '0;
      s_d.bphase = '0;
      s_d.pos = '0;
      s_d.gc = '0;
    end

    // Register bus: one wait cycle, completion at the second edge after the request.
    bus_wr = avs_write && !s_q.wait_q;
    s_d.wait_q = !((avs_read || avs_write) && s_q.wait_q);
    if (avs_read && s_q.wait_q) begin
      case (avs_address)
        REG_CTRL: s_d.rdata = 32'(s_q.ctrl);
        REG_FLAGS: s_d.rdata = 32'(s_q.flags);
        REG_ROUTE: s_d.rdata = 32'(s_q.route);
        REG_CRC: s_d.rdata = s_q.prev[0][0];
        default: s_d.rdata = '0;
      endcase
    end
    if (bus_wr && avs_address == REG_CTRL) begin
      s_d.ctrl = ctrl_t'(avs_writedata[CTRL_W-1:0]);
    end
    if (bus_wr && avs_address == REG_ROUTE) begin
      s_d.route = route_t'(avs_writedata[ROUTE_W-1:0]);
      s_d.route.fl = s_d.route.fl & FLOOD_OK;
    end
    // A new event in the clearing cycle survives the clear.
    s_d.flags = (s_q.flags & ~((bus_wr && avs_address == REG_FLAGS)
              ? flags_t'(avs_writedata[FLAGS_W-1:0]) : flags_t'('0))) | set;

    cls = {|s_q.flags.crc, s_q.flags.resp, s_q.flags.eoc, s_q.flags.ovf, s_q.flags.prot};
    s_d.fl_o = |(cls & s_q.route.fl);
    s_d.fat_o = |(cls & s_q.route.fat);
    s_d.nf_o = |(cls & s_q.route.nf);
  end

  function automatic logic [2:0] shamt_g(input logic [1:0] g, input logic [1:0] sh);
    return 3'(g << (2'h3 - sh));
  endfunction

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.wait_q <= 1'b1;
      // The link-reset synchroniser rests at the released level, so leaving reset
      // is never mistaken for a chain-down edge.
      s_q.rstn_s <= 3'h7;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = s_q.wait_q;
  assign tx_take_q = s_q.take;
  assign tx_cad_q = s_q.cad_o;
  assign tx_ctl_q = s_q.ctl_o;
  assign nxa_rsp_q = s_q.rsp;
  assign np_flush_q = s_q.flush;
  assign flood_req_q = s_q.fl_o;
  assign fatal_q = s_q.fat_o;
  assign nonfatal_q = s_q.nf_o;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer not in one cycle");
  eoc_nxa_a: assert property (dir_pkt.valid && !dir_pkt.posted && s_q.ctrl.eoc
      |=> nxa_rsp_q.valid && nxa_rsp_q.nxa && nxa_rsp_q.data == 32'hFFFFFFFF
      && (!s_q.flags.eoc || $past(s_q.flags.eoc))) else $error("nonposted drop not answered");
  eoc_posted_a: assert property (dir_pkt.valid && dir_pkt.posted && s_q.ctrl.eoc
      |=> s_q.flags.eoc && !nxa_rsp_q.valid) else $error("posted drop not logged");
  ovf_flag_a: assert property (pkt_ev.no_buffer |=> s_q.flags.ovf)
    else $error("overflow not logged");
  prot_cmd_a: assert property (pkt_ev.cmd_valid && pkt_ev.has_data
      && pkt_ev.data_pending |=> s_q.flags.prot) else $error("data command overlap not logged");
  resp_tag_a: assert property (resp_in.valid && !resp_in.tag_outstanding
      |=> s_q.flags.resp) else $error("unknown tag not logged");
  flag_sticky_a: assert property (s_q.flags.prot
      && !(avs_write && !avs_waitrequest && avs_address == REG_FLAGS)
      |=> s_q.flags.prot) else $error("protocol flag dropped without clear");
  crc_slot_a: assert property (tx_ins |=> tx_ctl_q && !tx_take_q)
    else $error("check beat without CTL high");
  first_win_a: assert property (s_q.st[1] == LS_FIRST |-> !tx_ins)
    else $error("check value in first window");
  flush_a: assert property ($rose(s_q.flood) |-> np_flush_q)
    else $error("flood without flush");
  crc_hold_a: assert property ($rose(|s_q.flags.crc) |-> $past(s_q.holding))
    else $error("check error set without hold-off");

  crc_err_c: cover property ($rose(|s_q.flags.crc));
  tx_check_c: cover property (tx_ins ##1 !tx_ins);
  flood_c: cover property ($rose(s_q.flood));
  nxa_c: cover property (nxa_rsp_q.valid);

endmodule

// *** bench/link_peer.sv ***
`timescale 1ns/1ps
module link_peer import link_crc_pkg::*; (
  // Link pins driven toward the block
  output logic link_clk,
  output logic [31:0] link_cad_in,
  output logic link_ctl_in,
  output logic link_reset_n
);
  logic [31:0] acc [4];
  logic [31:0] sent [4];
  logic [31:0] last0;
  // The link clock stands still between frames, so no bit-time is seen while idle.
  initial begin
    link_clk = 1'b0;
    link_cad_in = 32'h0;
    link_ctl_in = 1'b1;
    link_reset_n = 1'b1;
  end
  task automatic beat(input logic [31:0] cad, input logic ctl, input logic sum);
    logic b;
    logic t;
    link_cad_in = cad;
    link_ctl_in = ctl;
    if (sum) begin
      for (int l = 0; l < 4; l++) begin
        for (int i = 0; i < 9; i++) begin
          b = (i < 8) ? cad[8*l+i] : (l == 0) && ctl;
          t = acc[l][31];
          acc[l] = {acc[l][30:0], b} ^ (t ? CRC_POLY : 32'h0);
        end
      end
    end
    #62.5 link_clk = 1'b1;
    #62.5 link_clk = 1'b0;
  endtask
  // Three windows; the check value carried in the third has lane 2 corrupted.
  task automatic run();
    int j;
    for (int w = 0; w < 3; w++) begin
      for (int l = 0; l < 4; l++) sent[l] = ~acc[l];
      if (w == 2) begin
        last0 = acc[0];
        sent[2][0] = ~sent[2][0];
      end
      for (int l = 0; l < 4; l++) acc[l] = CRC_SEED;
      for (int b = 0; b < (w == 0 ? 512 : (w == 1 ? 516 : 90)); b++) begin
        j = b - 64;
        if (w > 0 && b >= 64 && b < 68) begin
          beat({sent[3][8*j+:8], sent[2][8*j+:8], sent[1][8*j+:8], sent[0][8*j+:8]}, 1'b1, 1'b0);
        end else begin
          beat({4{8'(b * 7 + 3)}} ^ {8'(w), 24'h5A3C0F}, 1'b1, 1'b1);
        end
      end
    end
  endtask
  task automatic flood();
    repeat (20) beat(32'hFFFFFFFF, 1'b1, 1'b0);
  endtask
endmodule

// *** bench/link_crc_and_error_detect_test.sv ***
`timescale 1ns/1ps
module link_crc_and_error_detect_test;
  import link_crc_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [31:0] rdata;
  logic link_clk;
  logic [31:0] link_cad_in;
  logic link_ctl_in;
  logic link_reset_n;
  pkt_ev_t pkt_ev = '0;
  dir_pkt_t dir_pkt = '0;
  logic inb_unaccepted = 1'b0;
  resp_in_t resp_in = '0;
  rsp_out_t nxa_rsp_q;
  rsp_out_t nxa_seen = '0;
  logic np_flush_q;
  logic saw_flush = 1'b0;
  logic tx_take_q;
  int takes = 0;
  logic fatal_q;
  logic nonfatal_q;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [13:0] rcase [7] = '{14'h2A22, 14'h3C11, 14'h3200, 14'h3A32, 14'h3922, 14'h3A22, 14'h3911};
  logic [31:0] ctl_v [3] = '{32'h034, 32'h044, 32'h064};

  always #4 mclk = ~mclk;

  link_crc_err #(.CTL_TO_SHORT_CYC(27'h0000014), .CTL_TO_LONG_CYC(27'h0000028)) u_link_crc_err (
    .mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link_clk(link_clk), .link_cad_in(link_cad_in),
    .link_ctl_in(link_ctl_in), .link_reset_n(link_reset_n), .tx_cad(32'h0), .tx_ctl(1'b1),
    .tx_take_q(tx_take_q), .tx_cad_q(), .tx_ctl_q(), .pkt_ev(pkt_ev), .dir_pkt(dir_pkt),
    .inb_unaccepted(inb_unaccepted), .resp_in(resp_in), .nxa_rsp_q(nxa_rsp_q),
    .np_flush_q(np_flush_q), .flood_req_q(), .fatal_q(fatal_q), .nonfatal_q(nonfatal_q));

  link_peer peer (.link_clk(link_clk), .link_cad_in(link_cad_in), .link_ctl_in(link_ctl_in),
    .link_reset_n(link_reset_n));

  task automatic wrap_up();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // One-cycle answers are latched here so a check never races the pulse.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (nxa_rsp_q.valid === 1'b1) nxa_seen <= nxa_rsp_q;
    if (np_flush_q === 1'b1) saw_flush <= 1'b1;
    if (tx_take_q === 1'b1) takes <= takes + 1;
    if (cycles == 40000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask

  // Kind 0 packet event, 1 directed packet, 2 inbound unaccepted, 3 response.
  task automatic ev_chk(input int k, input logic [13:0] v, input logic [9:0] m);
    @(posedge mclk);
    if (k == 0) pkt_ev <= pkt_ev_t'(v[4:0]);
    else if (k == 1) dir_pkt <= dir_pkt_t'(v[2:0]);
    else if (k == 2) inb_unaccepted <= 1'b1;
    else resp_in <= resp_in_t'(v);
    @(posedge mclk);
    pkt_ev <= '0;
    dir_pkt <= '0;
    inb_unaccepted <= 1'b0;
    resp_in <= '0;
    repeat (3) @(posedge mclk);
    rd(REG_FLAGS, {22'h0, m});
    if (m == 10'h020) chk(nonfatal_q, 1'b1);
    bus(1'b1, REG_FLAGS, 32'h3FF);
    rd(REG_FLAGS, 32'h0);
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd(REG_FLAGS, 32'h0);
    rd(4'h2, 32'h0);
    bus(1'b1, REG_ROUTE, 32'h400);
    bus(1'b1, REG_CTRL, 32'h034);
    ev_chk(1, 14'h5, 10'h000);
    chk(nxa_seen, {4'hF, 32'hFFFFFFFF});
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, REG_CTRL, ctl_v[i]);
      ev_chk(1, 14'h6, (i == 2) ? 10'h000 : 10'h080);
    end
    ev_chk(0, 14'h12, 10'h040);
    ev_chk(0, 14'h14, 10'h020);
    ev_chk(0, 14'h19, 10'h020);
    ev_chk(2, 14'h0, 10'h100);
    for (int i = 0; i < 7; i++) begin
      ev_chk(3, rcase[i], (i < 5) ? 10'h200 : 10'h000);
    end
    bus(1'b1, REG_ROUTE, 32'h200);
    bus(1'b1, REG_CTRL, 32'h124);
    peer.run();
    repeat (10) @(posedge mclk);
    rd(REG_FLAGS, 32'h004);
    rd(REG_CRC, peer.last0);
    chk(fatal_q, 1'b1);
    // 1118 bit-times were sent; eight of them carried check beats, which take nothing.
    chk(takes, 36'h456);
    chk(saw_flush, 1'b0);
    bus(1'b1, REG_FLAGS, 32'h3FF);
    peer.flood();
    repeat (10) @(posedge mclk);
    rd(REG_FLAGS, 32'h010);
    chk(saw_flush, 1'b1);
    bus(1'b1, REG_FLAGS, 32'h3FF);
    peer.beat(32'h0, 1'b0, 1'b0);
    repeat (30) @(posedge mclk);
    rd(REG_FLAGS, 32'h020);
    wrap_up();
  end
endmodule
